//--- inc/poc_pkg.sv
// constants, register layouts and carrier types of the output configuration bank
// assumes a 20 MHz pclk and a 32-bit apb with byte addresses on paddr
package poc_pkg;
  // clock and derived cycle scales
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;

  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_LINK = 8'h00;
  localparam logic [7:0] OFF_INIT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [15:0] LINK_RESET = 16'h0000;
  localparam logic [15:0] INIT_RESET = 16'h0000;

  // bit rates and the cycles of one bit (bit time rounded down)
  localparam int RATE_SLOW_BPS = 125_000;
  localparam int RATE_FAST_BPS = 189_000;
  localparam logic [7:0] BIT_CYC_SLOW = 8'(CLK_HZ / RATE_SLOW_BPS);
  localparam logic [7:0] BIT_CYC_FAST = 8'(CLK_HZ / RATE_FAST_BPS);

  // free-running repetition periods and the long phase I hold
  localparam int PERIOD_0_US = 1000;
  localparam int PERIOD_1_US = 500;
  localparam int PERIOD_2_US = 300;
  localparam int PERIOD_3_US = 250;
  localparam int PHASE1_MS = 100;
  localparam int TIMER_W = 22;

  // frame composition
  localparam logic [4:0] WIDTH_BASE = 5'h09;
  localparam logic [3:0] CODE_WIDTH_9 = 4'h0;
  localparam logic [3:0] CODE_WIDTH_10 = 4'h1;
  localparam logic [5:0] START_BITS = 6'h02;
  localparam logic [5:0] CTRL_BITS = 6'h03;
  localparam logic [5:0] CRC_BITS = 6'h03;
  localparam logic [5:0] PARITY_BITS = 6'h01;
  localparam logic [5:0] STATUS_BITS = 6'h01;
  localparam logic [2:0] CTRL_POS = 3'h1;
  localparam logic [2:0] CTRL_SPD = 3'h2;
  localparam logic [1:0] SLOT_ONE = 2'h0;
  localparam logic [1:0] SLOT_TWO = 2'h1;
  localparam logic [1:0] SLOT_THREE = 2'h2;
  localparam int ID_NIBBLES = 32;
  localparam logic [1:0] SEQ_AFTER_ONE = 2'h0;
  localparam logic [1:0] SEQ_AFTER_TWO = 2'h1;

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_APP} poc_phase_t;

  typedef struct packed {
    logic speed_en;
    logic parity_check;
    logic sync_mode;
    logic fast_rate;
    logic current_sel;
    logic status_en;
    logic status_err;
    logic third_slot;
    logic [1:0] period_sel;
    logic [1:0] nibble_rep;
    logic [3:0] payload_code;
  } poc_link_t;

  typedef struct packed {
    logic [6:0] phase3_repeat_count;
    logic phase1_length_select;
    logic error_code_en;
    logic ctrl_rolling;
    logic ctrl_en;
    logic [1:0] init_seq;
    logic [2:0] primary_code;
  } poc_init_t;

  typedef struct packed {
    logic [21:0] zero;
    logic cfg_conflict;
    logic ph1_elapsed;
    logic [2:0] roll;
    logic sending;
    logic [1:0] slot;
    logic [1:0] phase;
  } poc_status_t;

  typedef struct packed {
    logic start;
    logic [1:0] slot;
    logic is_speed;
    logic [2:0] ctrl;
    logic check_parity;
    logic status_en;
    logic status_flag;
    logic [7:0] bit_cycles;
    logic [4:0] data_width;
    logic [4:0] primary_width;
    logic [1:0] phase;
    logic [2:0] nibble_repeat;
    logic payload_err;
    logic defect_only;
  } poc_frame_t;
endpackage

//--- hw/poc_timer.sv
// loadable down counter: done pulses in the same cycle that the count reaches zero
// assumes load is not held while a count is wanted to finish
`timescale 1ns/1ns
`default_nettype none
module poc_timer #(
  parameter int W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt;

  // count down after a load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  // expiry pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= !load && (cnt == W'(1));
    end
  end

  // busy leaves load out, so a reload that is driven from busy cannot loop back on itself
  assign busy = (cnt != '0);
endmodule // poc_timer
`default_nettype wire

//--- hw/poc_output_config.sv
// output transmitter configuration bank with apb slave and frame scheduler
// assumes apb master in pclk domain; sync_pulse and sensor_error are synchronous
// Operation
// (R1) bit 15 set adds angular speed frames beside position
// (R2) bit 14 picks parity bit instead of crc
// (R3) bit 13 set sends only on sync pulses, else free-running
// (R4) bit 12 picks 189 kbps, clear gives 125 kbps
// (R5) bit 10 includes the status flag in each frame
// (R6) bit 9 lets the status flag carry error information
// (R7) bit 8 moves speed from slot 2 to slot 3
// (R8) bits 7:6 pick free-running period 1000, 500, 300 or 250 us
// (R9) bits 5:4 plus one repeat each phase II nibble
// (R10) bits 3:0 plus nine give frame data width
// (R11) software avoids 9-bit width with errors or phases II and III
// (R12) software keeps data width at least the signal widths
// (R13) phase III repeats two times field plus one
// (R14) phase I lasts 100 ms when selected, else minimal
// (R15) error codes go into the payload only when enabled
// (R16) three frame control bits are added when enabled
// (R17) control bits carry 001/010 or a rolling counter
// (R18) bits 4:3 choose after which phase application mode starts
// (R19) primary width is nine plus bits 2:0
// (R20) at 10-bit width an error sends only the defect code
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module poc_output_config #(
  parameter int PERIOD_0_CYC = poc_pkg::PERIOD_0_US * poc_pkg::CYC_PER_US,
  parameter int PERIOD_1_CYC = poc_pkg::PERIOD_1_US * poc_pkg::CYC_PER_US,
  parameter int PERIOD_2_CYC = poc_pkg::PERIOD_2_US * poc_pkg::CYC_PER_US,
  parameter int PERIOD_3_CYC = poc_pkg::PERIOD_3_US * poc_pkg::CYC_PER_US,
  parameter int PHASE1_CYC = poc_pkg::PHASE1_MS * poc_pkg::CYC_PER_MS,
  // bit time used only to space slots; the defaults equal the line bit times
  parameter int SLOT_BIT_SLOW_CYC = int'(poc_pkg::BIT_CYC_SLOW),
  parameter int SLOT_BIT_FAST_CYC = int'(poc_pkg::BIT_CYC_FAST)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [poc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_pulse,
  input wire logic sensor_error,
  output poc_pkg::poc_frame_t frame
);
  poc_pkg::poc_link_t link_q;
  poc_pkg::poc_init_t init_q;
  poc_pkg::poc_phase_t phase_q;
  poc_pkg::poc_status_t status;
  logic access, complete, hit_link, hit_init, hit_status;
  logic [31:0] rd_data;
  logic sending_q, ph1_armed_q, ph1_elapsed_q;
  logic [1:0] slot_q, last_slot, next_slot;
  logic [2:0] roll_q, next_ctrl;
  logic [8:0] phase_cnt_q, ph2_last, ph3_last;
  logic per_busy, per_done, gap_done, ph1_done;
  logic [poc_pkg::TIMER_W-1:0] period_cyc, gap_cyc;
  logic [poc_pkg::TIMER_W-1:0] slot_bit_cyc;
  logic [5:0] frame_bits;
  logic [7:0] bit_cyc;
  logic [4:0] width;
  logic trig, issue, next_speed, phase_end, cfg_conflict, defect_only;

  // apb decode; a transfer completes in the second access cycle
  assign access = psel && penable;
  assign complete = access && pready;
  assign hit_link = (paddr == poc_pkg::OFF_LINK);
  assign hit_init = (paddr == poc_pkg::OFF_INIT);
  assign hit_status = (paddr == poc_pkg::OFF_STATUS);

  // status word showing scheduler state
  always_comb begin
    status = '0;
    status.cfg_conflict = cfg_conflict;
    status.ph1_elapsed = ph1_elapsed_q;
    status.roll = roll_q;
    status.sending = sending_q;
    status.slot = slot_q;
    status.phase = phase_q;
  end

  // read mux; registers sit in the low half, upper bits zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_link) begin
      rd_data = {16'h0000, link_q};
    end else if (hit_init) begin
      rd_data = {16'h0000, init_q};
    end else if (hit_status) begin
      rd_data = status;
    end
  end

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= access && !pready && !(hit_link || hit_init || hit_status);
    end
  end

  // link format register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= poc_pkg::LINK_RESET;
    end else if (complete && pwrite && hit_link) begin
      link_q <= pwdata[15:0];
    end
  end

  // init and framing register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= poc_pkg::INIT_RESET;
    end else if (complete && pwrite && hit_init) begin
      init_q <= pwdata[15:0];
    end
  end

  // period, bit time and frame length selection
  always_comb begin
    case (link_q.period_sel) // [R8]
      2'h0: period_cyc = poc_pkg::TIMER_W'(PERIOD_0_CYC);
      2'h1: period_cyc = poc_pkg::TIMER_W'(PERIOD_1_CYC);
      2'h2: period_cyc = poc_pkg::TIMER_W'(PERIOD_2_CYC);
      default: period_cyc = poc_pkg::TIMER_W'(PERIOD_3_CYC);
    endcase
    bit_cyc = link_q.fast_rate ? poc_pkg::BIT_CYC_FAST : poc_pkg::BIT_CYC_SLOW; // [R4]
    width = poc_pkg::WIDTH_BASE + 5'(link_q.payload_code); // [R10]
    frame_bits = poc_pkg::START_BITS + 6'(width)
      + (init_q.ctrl_en ? poc_pkg::CTRL_BITS : 6'h00) // [R16]
      + (link_q.status_en ? poc_pkg::STATUS_BITS : 6'h00)
      + (link_q.parity_check ? poc_pkg::PARITY_BITS : poc_pkg::CRC_BITS); // [R2]
    slot_bit_cyc = link_q.fast_rate ? poc_pkg::TIMER_W'(SLOT_BIT_FAST_CYC)
      : poc_pkg::TIMER_W'(SLOT_BIT_SLOW_CYC); // [R4]
    // both factors widened first so the product is not cut to the width of the factors
    gap_cyc = poc_pkg::TIMER_W'(frame_bits) * slot_bit_cyc;
  end

  // slot plan and trigger source
  always_comb begin
    last_slot = poc_pkg::SLOT_ONE;
    if (phase_q == poc_pkg::PH_APP && link_q.speed_en) begin // [R1]
      last_slot = link_q.third_slot ? poc_pkg::SLOT_THREE : poc_pkg::SLOT_TWO; // [R7]
    end
    trig = link_q.sync_mode ? sync_pulse : per_done; // [R3]
    issue = (trig && !sending_q) || (gap_done && sending_q && slot_q != last_slot);
    next_slot = sending_q ? slot_q + 2'h1 : poc_pkg::SLOT_ONE;
    next_speed = (last_slot != poc_pkg::SLOT_ONE) && (next_slot == last_slot);
  end

  // frame control code
  always_comb begin
    next_ctrl = 3'h0;
    if (init_q.ctrl_en) begin // [R16]
      next_ctrl = init_q.ctrl_rolling ? roll_q : (next_speed ? poc_pkg::CTRL_SPD : poc_pkg::CTRL_POS); // [R17]
    end
  end

  // phase ends and conflict checks
  always_comb begin
    ph2_last = 9'(poc_pkg::ID_NIBBLES * (int'(link_q.nibble_rep) + 1) - 1); // [R9]
    ph3_last = 9'(2 * (int'(init_q.phase3_repeat_count) + 1) - 1); // [R13]
    case (phase_q)
      poc_pkg::PH_ONE: phase_end = !init_q.phase1_length_select || ph1_elapsed_q; // [R14]
      poc_pkg::PH_TWO: phase_end = (phase_cnt_q == ph2_last);
      poc_pkg::PH_THREE: phase_end = (phase_cnt_q == ph3_last);
      default: phase_end = 1'b0;
    endcase
    cfg_conflict = (link_q.payload_code == poc_pkg::CODE_WIDTH_9)
      && (link_q.status_err || init_q.error_code_en || init_q.init_seq != poc_pkg::SEQ_AFTER_ONE); // [R11]
    defect_only = sensor_error && init_q.error_code_en && (link_q.payload_code == poc_pkg::CODE_WIDTH_10); // [R20]
  end

  // free-running period timer, reloaded whenever it runs out while sync_mode is clear
  poc_timer #(.W(poc_pkg::TIMER_W)) u_period (
    .pclk(pclk),
    .presetn(presetn),
    .load(!per_busy && !link_q.sync_mode),
    .value(period_cyc),
    .busy(per_busy),
    .done(per_done)
  );

  // spacing between slots of one cycle
  poc_timer #(.W(poc_pkg::TIMER_W)) u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .load(issue),
    .value(gap_cyc),
    .busy(),
    .done(gap_done)
  );

  // phase I hold timer
  poc_timer #(.W(poc_pkg::TIMER_W)) u_phase1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(phase_q == poc_pkg::PH_ONE && !ph1_armed_q),
    .value(poc_pkg::TIMER_W'(PHASE1_CYC)),
    .busy(),
    .done(ph1_done)
  );

  // phase I hold bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph1_armed_q <= 1'b0;
      ph1_elapsed_q <= 1'b0;
    end else begin
      ph1_armed_q <= 1'b1;
      if (ph1_done) begin
        ph1_elapsed_q <= 1'b1; // [R14]
      end
    end
  end

  // slot sequencing inside one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sending_q <= 1'b0;
      slot_q <= poc_pkg::SLOT_ONE;
    end else if (issue) begin
      sending_q <= 1'b1;
      slot_q <= next_slot;
    end else if (gap_done) begin
      sending_q <= 1'b0;
    end
  end

  // rolling frame counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roll_q <= 3'h0;
    end else if (issue && init_q.ctrl_en && init_q.ctrl_rolling) begin
      roll_q <= roll_q + 3'h1; // [R17]
    end
  end

  // initialization phase sequencer, advanced by issued frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= poc_pkg::PH_ONE;
      phase_cnt_q <= 9'h000;
    end else if (issue && phase_q != poc_pkg::PH_APP) begin
      phase_cnt_q <= phase_end ? 9'h000 : phase_cnt_q + 9'h001;
      if (phase_end) begin
        case (phase_q) // [R18]
          poc_pkg::PH_ONE: phase_q <= (init_q.init_seq == poc_pkg::SEQ_AFTER_ONE) ? poc_pkg::PH_APP : poc_pkg::PH_TWO;
          poc_pkg::PH_TWO: phase_q <= (init_q.init_seq == poc_pkg::SEQ_AFTER_TWO) ? poc_pkg::PH_APP : poc_pkg::PH_THREE;
          default: phase_q <= poc_pkg::PH_APP;
        endcase
      end
    end
  end

  // frame descriptor handed to the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame <= '0;
    end else begin
      frame.start <= issue;
      if (issue) begin
        frame.slot <= next_slot;
        frame.is_speed <= next_speed; // [R1] [R7]
        frame.ctrl <= next_ctrl;
        frame.check_parity <= link_q.parity_check; // [R2]
        frame.status_en <= link_q.status_en; // [R5]
        frame.status_flag <= link_q.status_en && link_q.status_err && sensor_error; // [R6]
        frame.bit_cycles <= bit_cyc; // [R4]
        frame.data_width <= width; // [R10]
        frame.primary_width <= poc_pkg::WIDTH_BASE + 5'(init_q.primary_code); // [R19]
        frame.phase <= phase_q;
        frame.nibble_repeat <= 3'(link_q.nibble_rep) + 3'h1; // [R9]
        frame.payload_err <= sensor_error && init_q.error_code_en && !defect_only; // [R15]
        frame.defect_only <= defect_only; // [R20]
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence link_write_s;
    psel && penable && pready && pwrite && paddr == poc_pkg::OFF_LINK;
  endsequence

  sequence sync_start_s;
    frame.start && frame.slot == poc_pkg::SLOT_ONE && $past(link_q.sync_mode);
  endsequence

  link_write_takes_a: assert property (link_write_s |=> link_q == $past(pwdata[15:0])) // [R1]
    else $error("link format write not stored");
  sync_trigger_a: assert property (sync_start_s |-> $past(sync_pulse) && !$past(sending_q)) // [R3]
    else $error("synchronous frame without sync pulse");
  check_kind_a: assert property (frame.start |-> frame.check_parity == $past(link_q.parity_check)) // [R2]
    else $error("frame check kind mismatch");
  bit_rate_a: assert property (frame.start |-> frame.bit_cycles ==
    ($past(link_q.fast_rate) ? poc_pkg::BIT_CYC_FAST : poc_pkg::BIT_CYC_SLOW)) // [R4]
    else $error("bit time mismatch");
  data_width_a: assert property (frame.start |-> frame.data_width ==
    poc_pkg::WIDTH_BASE + 5'($past(link_q.payload_code))) // [R10]
    else $error("data width mismatch");
  speed_slot_a: assert property (frame.start && frame.is_speed |-> $past(link_q.speed_en) &&
    frame.slot == ($past(link_q.third_slot) ? poc_pkg::SLOT_THREE : poc_pkg::SLOT_TWO)) // [R7]
    else $error("speed frame in wrong slot");
  fixed_ctrl_a: assert property (frame.start && $past(init_q.ctrl_en) && !$past(init_q.ctrl_rolling) |->
    frame.ctrl == (frame.is_speed ? poc_pkg::CTRL_SPD : poc_pkg::CTRL_POS)) // [R17]
    else $error("fixed control code wrong");
  no_ctrl_a: assert property (frame.start && !$past(init_q.ctrl_en) |-> frame.ctrl == 3'h0) // [R16]
    else $error("control bits present while disabled");
  primary_width_a: assert property (frame.start |-> frame.primary_width ==
    poc_pkg::WIDTH_BASE + 5'($past(init_q.primary_code))) // [R19]
    else $error("primary width mismatch");
  status_flag_a: assert property (frame.start && frame.status_flag |-> frame.status_en
    && $past(link_q.status_err) && $past(sensor_error)) // [R6]
    else $error("status flag without cause");
  defect_code_a: assert property (frame.start && frame.defect_only |-> !frame.payload_err
    && $past(link_q.payload_code) == poc_pkg::CODE_WIDTH_10) // [R20]
    else $error("defect-only outside 10-bit width");
  status_omit_a: assert property (frame.start && !frame.status_en |-> !frame.status_flag) // [R5]
    else $error("status flag sent while disabled");
  payload_err_a: assert property (frame.start && frame.payload_err |-> $past(init_q.error_code_en)) // [R15]
    else $error("payload error code while disabled");
  nibble_rep_a: assert property (frame.start |-> frame.nibble_repeat == 3'($past(link_q.nibble_rep)) + 3'h1) // [R9]
    else $error("nibble repeat mismatch");
  single_slot_a: assert property (frame.start && !$past(link_q.speed_en) |-> !frame.is_speed) // [R1]
    else $error("speed frame while speed disabled");
  slot_chain_a: assert property (frame.start && frame.slot != poc_pkg::SLOT_ONE |-> $past(sending_q)) // [R7]
    else $error("later slot without a running cycle");
endmodule // poc_output_config
`default_nettype wire

//--- test/poc_ecu_model.sv
// ecu receiver model: issues one-cycle sync triggers and logs frame starts
// assumes the frame carrier of the configuration bank in the pclk domain
`timescale 1ns/1ns
`default_nettype none
module poc_ecu_model (
  input wire logic pclk,
  input wire poc_pkg::poc_frame_t frame,
  output logic sync_pulse
);
  int cyc = 0;
  int t_trig = 0;
  int n_starts = 0;

  initial sync_pulse = 1'b0;

  // trigger launched after an edge, idle low between triggers
  task send_sync();
    @(posedge pclk);
    sync_pulse <= 1'b1;
    @(posedge pclk);
    sync_pulse <= 1'b0;
  endtask

  // log the trigger cycle and count received frames
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sync_pulse === 1'b1) begin
      t_trig <= cyc;
    end
    if (frame.start === 1'b1) begin
      n_starts <= n_starts + 1;
    end
  end
endmodule // poc_ecu_model
`default_nettype wire

//--- test/poc_output_config_tb.sv
// self-checking bench for the output configuration bank
// assumes shortened period and phase I parameters; the ecu model makes sync_pulse
`timescale 1ns/1ns
`default_nettype none
module poc_output_config_tb;
  localparam int P3 = 150;
  // shortened slot bit times keep every frame inside the shortened periods
  localparam int SLOW = 4;
  localparam int FAST = 3;
  localparam int GAP = (2 + 10 + 3 + 3) * SLOW + 1;
  localparam int LIMIT = 60000;
  typedef struct {logic [15:0] link; logic [15:0] init; logic [7:0] bitc; logic [4:0] dw; logic [4:0] pw;
    logic [2:0] nrep; int per;} poc_row_t;
  typedef struct {logic [15:0] link; logic [15:0] init; logic err; logic [2:0] exp;} poc_err_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sensor_error, sync_pulse, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] prev;
  poc_pkg::poc_frame_t frame;
  int cyc = 0;
  int fail_count = 0;
  int n_checks = 0;
  int t, t0, n, i, s, k;
  // widths chosen so data width covers the primary width
  poc_row_t rows [4] = '{
    '{16'h0000, 16'h0020, 8'hA0, 5'h09, 5'h09, 3'h1, 400},
    '{16'h5455, 16'h0025, 8'h69, 5'h0E, 5'h0E, 3'h2, 300},
    '{16'h40AF, 16'h0023, 8'hA0, 5'h18, 5'h0C, 3'h3, 200},
    '{16'h10FA, 16'h0021, 8'h69, 5'h13, 5'h0A, 3'h4, P3}};
  // error features only with widths above nine bits
  poc_err_t errs [4] = '{
    '{16'h26C1, 16'h00A1, 1'b1, 3'h5},
    '{16'h26C1, 16'h00A1, 1'b0, 3'h0},
    '{16'h24C1, 16'h0021, 1'b1, 3'h0},
    '{16'h26C3, 16'h00A1, 1'b1, 3'h6}};

  poc_output_config #(.PERIOD_0_CYC(400), .PERIOD_1_CYC(300), .PERIOD_2_CYC(200), .PERIOD_3_CYC(P3),
    .PHASE1_CYC(650), .SLOT_BIT_SLOW_CYC(SLOW), .SLOT_BIT_FAST_CYC(FAST))
    dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_pulse(sync_pulse), .sensor_error(sensor_error), .frame(frame));
  poc_ecu_model ecu (.pclk(pclk), .frame(frame), .sync_pulse(sync_pulse));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // cycle count and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 2);
  endtask

  // wait for a frame start, bounded
  task wstart(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frame.start !== 1'b1 && n < lim);
    if (n >= lim) chk(0, 1);
    t = cyc;
  endtask

  task do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sensor_error = 1'b0;
    do_reset();
    // reset values, unmapped read, ignored status write
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(er, 1'b0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, poc_pkg::OFF_STATUS, 32'hFFFF);
    chk(er, 1'b0);
    // free-running rows: readback, frame fields and period
    for (i = 0; i < 4; i++) begin
      apb(1'b1, poc_pkg::OFF_LINK, {16'hABCD, rows[i].link});
      apb(1'b1, poc_pkg::OFF_INIT, {16'hABCD, rows[i].init});
      apb(1'b0, poc_pkg::OFF_LINK, 32'h0);
      chk(rd, {16'h0, rows[i].link});
      apb(1'b0, poc_pkg::OFF_INIT, 32'h0);
      chk(rd, {16'h0, rows[i].init});
      wstart(500);
      wstart(500);
      t0 = t;
      wstart(500);
      chk((t - t0 >= rows[i].per) && (t - t0 <= rows[i].per + 2), 1);
      chk(frame.check_parity, rows[i].link[14]);
      chk(frame.status_en, rows[i].link[10]);
      chk(frame.bit_cycles, rows[i].bitc);
      chk(frame.data_width, rows[i].dw);
      chk(frame.primary_width, rows[i].pw);
      chk(frame.nibble_repeat, rows[i].nrep);
      chk({frame.slot, frame.is_speed, frame.ctrl, frame.phase}, {2'h0, 1'b0, 3'h1, 2'h3});
    end
    // synchronous cycles with two then three slots, a trigger in mid-cycle refused
    for (i = 0; i < 2; i++) begin
      apb(1'b1, poc_pkg::OFF_LINK, 32'hA0C1 | (i << 8));
      repeat (3000) @(posedge pclk);
      k = ecu.n_starts;
      repeat (200) @(posedge pclk);
      chk(ecu.n_starts, k);
      ecu.send_sync();
      wstart(10);
      chk(t - ecu.t_trig, 1);
      chk({frame.slot, frame.is_speed, frame.ctrl}, {2'h0, 1'b0, 3'h1});
      k = t;
      ecu.send_sync();
      for (s = 1; s <= 1 + i; s++) begin
        wstart(3000);
        chk(t - k, GAP);
        k = t;
        chk({frame.slot, frame.is_speed, frame.ctrl},
          (s == 1 + i) ? {2'(s), 1'b1, 3'h2} : {2'(s), 1'b0, 3'h1});
      end
      @(posedge pclk);
      k = ecu.n_starts;
      repeat (3000) @(posedge pclk);
      chk(ecu.n_starts, k);
    end
    // status flag, payload error and defect code against sensor_error
    for (i = 0; i < 4; i++) begin
      apb(1'b1, poc_pkg::OFF_LINK, {16'h0, errs[i].link});
      apb(1'b1, poc_pkg::OFF_INIT, {16'h0, errs[i].init});
      sensor_error <= errs[i].err;
      ecu.send_sync();
      wstart(10);
      chk({frame.status_flag, frame.payload_err, frame.defect_only}, errs[i].exp);
      repeat (3500) @(posedge pclk);
    end
    sensor_error <= 1'b0;
    // init phases: I once, II 32 x 2 frames, III 4 frames, then application
    do_reset();
    apb(1'b1, poc_pkg::OFF_LINK, 32'h00D1);
    apb(1'b1, poc_pkg::OFF_INIT, 32'h0271);
    for (i = 1; i <= 72; i++) begin
      wstart(500);
      chk(frame.phase, (i == 1) ? 0 : (i <= 65) ? 1 : (i <= 69) ? 2 : 3);
      if (i > 1) begin
        prev = prev + 3'h1;
        chk(frame.ctrl, prev);
      end
      prev = frame.ctrl;
      if (i == 2) chk(frame.nibble_repeat, 3'h2);
    end
    // long phase I holds past its first frames
    do_reset();
    t0 = cyc;
    apb(1'b1, poc_pkg::OFF_LINK, 32'h00C1);
    apb(1'b1, poc_pkg::OFF_INIT, 32'h0121);
    wstart(500);
    wstart(500);
    chk(frame.phase, 2'h0);
    while (cyc - t0 < 720) @(posedge pclk);
    wstart(300);
    chk(frame.phase, 2'h3);
    apb(1'b0, poc_pkg::OFF_STATUS, 32'h0);
    chk({rd[8], rd[1:0]}, 3'h7);
    final_report();
  end
endmodule // poc_output_config_tb
`default_nettype wire
